//--- dsam_pkg.sv
package dsam_pkg;
    // Data and register widths
    localparam int WORD_W = 16;
    localparam int CNT_W = 8;
    localparam int SRC_W = 4;
    localparam int ADDR_W = 8;

    // Register byte addresses
    localparam logic [7:0] ADDR_DIAG = 8'h3c;
    localparam logic [7:0] ADDR_THR1 = 8'h40;
    localparam logic [7:0] ADDR_THR2 = 8'h42;
    localparam logic [7:0] ADDR_CNT1 = 8'h44;
    localparam logic [7:0] ADDR_CNT2 = 8'h46;
    localparam logic [7:0] ADDR_CTRL = 8'h48;

    // Alarm control field positions
    localparam int CTRL_SRC2_LSB = 12;
    localparam int CTRL_SRC1_LSB = 8;
    localparam int CTRL_DYN2_BIT = 7;
    localparam int CTRL_DYN1_BIT = 6;
    localparam int CTRL_POL2_BIT = 5;
    localparam int CTRL_POL1_BIT = 4;
    localparam int CTRL_FILT_BIT = 3;
    localparam int CTRL_IND_EN_BIT = 2;
    localparam int CTRL_IND_POL_BIT = 1;
    localparam int CTRL_IND_SEL_BIT = 0;

    // Diagnostic status alarm flag positions
    localparam int DIAG_ALM1_BIT = 8;
    localparam int DIAG_ALM2_BIT = 9;

    // Reset values
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] THR_RST = 16'h0000;
    localparam logic [7:0] CNT_RST = 8'h00;
    localparam logic [1:0] FLAGS_RST = 2'h0;

    // Data source codes
    localparam logic [3:0] SRC_OFF = 4'h0;
    localparam logic [3:0] SRC_GX = 4'h1;
    localparam logic [3:0] SRC_GY = 4'h2;
    localparam logic [3:0] SRC_GZ = 4'h3;
    localparam logic [3:0] SRC_AX = 4'h4;
    localparam logic [3:0] SRC_AY = 4'h5;
    localparam logic [3:0] SRC_AZ = 4'h6;

    // Shortest dynamic comparison span, in samples
    localparam logic [7:0] SPAN_MIN = 8'h01;
endpackage : dsam_pkg

//--- dsam_alarm_channel.sv
`timescale 1ns/1ps
module dsam_alarm_channel #(
    parameter int WORD_W = 16,
    parameter int HIST_DEPTH = 256
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic sample_stb_in,
    input wire logic restart_in,
    input wire logic enable_in,
    input wire logic dynamic_in,
    input wire logic above_in,
    input wire logic [WORD_W-1:0] data_in,
    input wire logic [WORD_W-1:0] threshold_in,
    input wire logic [dsam_pkg::CNT_W-1:0] count_in,
    output logic hit_out
);
    localparam int PTR_W = $clog2(HIST_DEPTH);

    // History must hold the longest span and wrap cleanly
    if (HIST_DEPTH < (1 << dsam_pkg::CNT_W) || (1 << PTR_W) != HIST_DEPTH) begin : g_chk
        $error("HIST_DEPTH must be a power of two of at least 256");
    end

    logic [WORD_W-1:0] hist_mem [HIST_DEPTH];
    logic [PTR_W-1:0] wptr_r;
    logic [dsam_pkg::CNT_W-1:0] filled_r;
    logic [dsam_pkg::CNT_W-1:0] span;
    logic [PTR_W-1:0] rptr;
    logic [WORD_W-1:0] past;
    logic signed [WORD_W:0] delta;
    logic [WORD_W:0] delta_abs;
    logic signed [WORD_W:0] thr_ext;
    logic dyn_ready;
    logic static_hit;
    logic dyn_hit;

    assign span = (count_in <= dsam_pkg::SPAN_MIN) ? dsam_pkg::SPAN_MIN : count_in;
    assign rptr = wptr_r - PTR_W'(span);
    assign past = hist_mem[rptr];
    assign dyn_ready = filled_r >= span;

    assign delta = $signed({data_in[WORD_W-1], data_in}) - $signed({past[WORD_W-1], past});
    assign delta_abs = delta[WORD_W] ? (~delta + {{WORD_W{1'b0}}, 1'b1}) : delta;
    assign thr_ext = $signed({threshold_in[WORD_W-1], threshold_in});

    assign static_hit = above_in ? ($signed(data_in) > $signed(threshold_in))
                                 : ($signed(data_in) < $signed(threshold_in));
    assign dyn_hit = dyn_ready && (above_in ? ($signed(delta_abs) > thr_ext)
                                            : ($signed(delta_abs) < thr_ext));
    assign hit_out = enable_in && (dynamic_in ? dyn_hit : static_hit);

    // Ring pointer and fill count; only the fill count is cleared on reconfiguration
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            wptr_r <= '0;
            filled_r <= '0;
        end else if (restart_in) begin
            filled_r <= '0;
        end else if (sample_stb_in) begin
            wptr_r <= wptr_r + 1'b1;
            filled_r <= (&filled_r) ? filled_r : filled_r + 1'b1;
        end
    end

    // Sample history store
    always_ff @(posedge core_clk_in) begin
        if (sample_stb_in) begin
            hist_mem[wptr_r] <= data_in;
        end
    end

    a_span_single: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (count_in == 8'h00) |-> (rptr == wptr_r - 1'b1))
        else $error("Zero count does not look one sample back");
    a_dyn_fires: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (enable_in && dynamic_in && above_in && dyn_ready && ($signed(delta_abs) > thr_ext))
        |-> hit_out)
        else $error("Dynamic alarm missed a large change");
    a_dyn_waits: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (restart_in ##1 (!restart_in && dynamic_in && count_in == 8'h02)) |-> !hit_out)
        else $error("Dynamic alarm fired before its span was filled");
endmodule : dsam_alarm_channel

//--- dsam_indicator.sv
`timescale 1ns/1ps
module dsam_indicator (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic sample_stb_in,
    input wire logic alarm_in,
    input wire logic enable_in,
    input wire logic active_high_in,
    input wire logic pin_two_in,
    output logic gpio_one_out,
    output logic gpio_one_oe_n_out,
    output logic gpio_two_out,
    output logic gpio_two_oe_n_out
);
    logic active_r;
    logic level;
    logic drive_one;
    logic drive_two;

    assign level = active_r ? active_high_in : ~active_high_in;
    assign drive_one = enable_in && !pin_two_in;
    assign drive_two = enable_in && pin_two_in;

    // Latch alarm state and pin levels
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            active_r <= 1'b0;
            gpio_one_out <= 1'b0;
            gpio_one_oe_n_out <= 1'b1;
            gpio_two_out <= 1'b0;
            gpio_two_oe_n_out <= 1'b1;
        end else begin
            active_r <= sample_stb_in ? alarm_in : active_r;
            gpio_one_out <= drive_one && level;
            gpio_one_oe_n_out <= !drive_one;
            gpio_two_out <= drive_two && level;
            gpio_two_oe_n_out <= !drive_two;
        end
    end

    a_pin_released: assert property (@(posedge core_clk_in) disable iff (rst_in)
        !enable_in |=> (gpio_one_oe_n_out && gpio_two_oe_n_out))
        else $error("Pin driven while indicator disabled");
    a_pin_polarity: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (enable_in && sample_stb_in && alarm_in) ##1 (enable_in && $stable(active_high_in))
        |=> ((pin_two_in ? gpio_two_out : gpio_one_out) == active_high_in))
        else $error("Indicator level does not follow polarity");
    a_pin_route: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (enable_in && pin_two_in) |=> (!gpio_two_oe_n_out && gpio_one_oe_n_out))
        else $error("Indicator not routed to second pin");
endmodule : dsam_indicator

//--- dsam_alarm_top.sv
`timescale 1ns/1ps
// Operation
// - Alarm hits set diagnostic flags bits 9:8
// - Alarm two source field selects word
// - Alarm one source uses same encoding
// - Mode bit picks dynamic or static
// - Polarity bit picks above or below
// - Filter bit picks filtered data, both alarms
// - Indicator enable lets alarm drive pin
// - Indicator polarity high or low
// - Line select picks second or first pin
// - Control fields reset to zero
// - Dynamic alarm on change beyond threshold
// - Static compare in data word format
// - Dynamic alarm watches rate of change
// - Sample count zero or one means one
module dsam_alarm_top #(
    parameter int HIST_DEPTH = 256
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic sample_stb_in,
    input wire logic [15:0] gyro_x_output_in,
    input wire logic [15:0] gyro_y_output_in,
    input wire logic [15:0] gyro_z_output_in,
    input wire logic [15:0] accel_x_output_in,
    input wire logic [15:0] accel_y_output_in,
    input wire logic [15:0] accel_z_output_in,
    input wire logic [15:0] gyro_x_filt_in,
    input wire logic [15:0] gyro_y_filt_in,
    input wire logic [15:0] gyro_z_filt_in,
    input wire logic [15:0] accel_x_filt_in,
    input wire logic [15:0] accel_y_filt_in,
    input wire logic [15:0] accel_z_filt_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    output logic reg_rvalid_out,
    output logic general_io_pin_one_out,
    output logic general_io_pin_one_oe_n_out,
    output logic general_io_pin_two_out,
    output logic general_io_pin_two_oe_n_out
);
    // Register state
    logic [15:0] alarm_control_r;
    logic [15:0] alarm_one_threshold_r;
    logic [15:0] alarm_two_threshold_r;
    logic [7:0] alarm_one_sample_count_r;
    logic [7:0] alarm_two_sample_count_r;
    logic [1:0] flags_r;
    logic [1:0] flags_nxt;
    logic [15:0] rdata_r;
    logic rvalid_r;

    // Decoded control fields
    logic [3:0] src1;
    logic [3:0] src2;
    logic filt;
    logic en1;
    logic en2;
    logic hit1;
    logic hit2;

    // Source words after the filter choice
    logic [15:0] set_gx;
    logic [15:0] set_gy;
    logic [15:0] set_gz;
    logic [15:0] set_ax;
    logic [15:0] set_ay;
    logic [15:0] set_az;
    logic [15:0] sel1;
    logic [15:0] sel2;

    // Bus decode
    logic wr_ctrl;
    logic wr_thr1;
    logic wr_thr2;
    logic wr_cnt1;
    logic wr_cnt2;
    logic rd_diag;
    logic restart1;
    logic restart2;
    logic [1:0] flag_set;
    logic [1:0] flag_clr;
    logic [15:0] diag_word;
    logic [15:0] rd_word;

    // Maps a source code onto one of six words
    function automatic logic [15:0] pick_word(
        input logic [3:0] src,
        input logic [15:0] gx,
        input logic [15:0] gy,
        input logic [15:0] gz,
        input logic [15:0] ax,
        input logic [15:0] ay,
        input logic [15:0] az
    );
        case (src)
            dsam_pkg::SRC_GX: pick_word = gx;
            dsam_pkg::SRC_GY: pick_word = gy;
            dsam_pkg::SRC_GZ: pick_word = gz;
            dsam_pkg::SRC_AX: pick_word = ax;
            dsam_pkg::SRC_AY: pick_word = ay;
            dsam_pkg::SRC_AZ: pick_word = az;
            default: pick_word = 16'h0000;
        endcase
    endfunction : pick_word

    // True for a code that names a sensor word
    function automatic logic src_live(input logic [3:0] src);
        src_live = (src >= dsam_pkg::SRC_GX) && (src <= dsam_pkg::SRC_AZ);
    endfunction : src_live

    // Control field extraction
    assign src1 = alarm_control_r[dsam_pkg::CTRL_SRC1_LSB +: dsam_pkg::SRC_W];
    assign src2 = alarm_control_r[dsam_pkg::CTRL_SRC2_LSB +: dsam_pkg::SRC_W];
    assign filt = alarm_control_r[dsam_pkg::CTRL_FILT_BIT];

    assign en1 = src_live(src1);
    assign en2 = src_live(src2);

    // filtered or raw set for both
    assign set_gx = filt ? gyro_x_filt_in : gyro_x_output_in;
    assign set_gy = filt ? gyro_y_filt_in : gyro_y_output_in;
    assign set_gz = filt ? gyro_z_filt_in : gyro_z_output_in;
    assign set_ax = filt ? accel_x_filt_in : accel_x_output_in;
    assign set_ay = filt ? accel_y_filt_in : accel_y_output_in;
    assign set_az = filt ? accel_z_filt_in : accel_z_output_in;

    assign sel1 = pick_word(src1, set_gx, set_gy, set_gz, set_ax, set_ay, set_az);
    assign sel2 = pick_word(src2, set_gx, set_gy, set_gz, set_ax, set_ay, set_az);

    // Register address decode
    assign wr_ctrl = reg_wr_in && (reg_addr_in == dsam_pkg::ADDR_CTRL);
    assign wr_thr1 = reg_wr_in && (reg_addr_in == dsam_pkg::ADDR_THR1);
    assign wr_thr2 = reg_wr_in && (reg_addr_in == dsam_pkg::ADDR_THR2);
    assign wr_cnt1 = reg_wr_in && (reg_addr_in == dsam_pkg::ADDR_CNT1);
    assign wr_cnt2 = reg_wr_in && (reg_addr_in == dsam_pkg::ADDR_CNT2);
    assign rd_diag = reg_rd_in && (reg_addr_in == dsam_pkg::ADDR_DIAG);
    assign restart1 = wr_ctrl || wr_cnt1;
    assign restart2 = wr_ctrl || wr_cnt2;

    assign flag_set = {sample_stb_in && hit2, sample_stb_in && hit1};
    assign flag_clr = rd_diag ? 2'h3 : 2'h0;
    assign flags_nxt = (flags_r & ~flag_clr) | flag_set;
    assign diag_word = {{(15 - dsam_pkg::DIAG_ALM2_BIT){1'b0}}, flags_r,
                        {dsam_pkg::DIAG_ALM1_BIT{1'b0}}};

    // Read data selection, unmapped reads as zero
    assign rd_word = (reg_addr_in == dsam_pkg::ADDR_DIAG) ? diag_word :
                     (reg_addr_in == dsam_pkg::ADDR_THR1) ? alarm_one_threshold_r :
                     (reg_addr_in == dsam_pkg::ADDR_THR2) ? alarm_two_threshold_r :
                     (reg_addr_in == dsam_pkg::ADDR_CNT1) ? {8'h00, alarm_one_sample_count_r} :
                     (reg_addr_in == dsam_pkg::ADDR_CNT2) ? {8'h00, alarm_two_sample_count_r} :
                     (reg_addr_in == dsam_pkg::ADDR_CTRL) ? alarm_control_r : 16'h0000;

    assign reg_rdata_out = rdata_r;
    assign reg_rvalid_out = rvalid_r;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            alarm_control_r <= dsam_pkg::CTRL_RST;
            alarm_one_threshold_r <= dsam_pkg::THR_RST;
            alarm_two_threshold_r <= dsam_pkg::THR_RST;
            alarm_one_sample_count_r <= dsam_pkg::CNT_RST;
            alarm_two_sample_count_r <= dsam_pkg::CNT_RST;
        end else begin
            if (wr_ctrl) alarm_control_r <= reg_wdata_in;
            if (wr_thr1) alarm_one_threshold_r <= reg_wdata_in;
            if (wr_thr2) alarm_two_threshold_r <= reg_wdata_in;
            if (wr_cnt1) alarm_one_sample_count_r <= reg_wdata_in[7:0];
            if (wr_cnt2) alarm_two_sample_count_r <= reg_wdata_in[7:0];
        end
    end

    // Flags and read return
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            flags_r <= dsam_pkg::FLAGS_RST;
            rdata_r <= 16'h0000;
            rvalid_r <= 1'b0;
        end else begin
            flags_r <= flags_nxt;
            rdata_r <= reg_rd_in ? rd_word : rdata_r;
            rvalid_r <= reg_rd_in;
        end
    end

    dsam_alarm_channel #(
        .WORD_W(dsam_pkg::WORD_W),
        .HIST_DEPTH(HIST_DEPTH)
    ) u_alarm_one (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .sample_stb_in(sample_stb_in),
        .restart_in(restart1),
        .enable_in(en1),
        .dynamic_in(alarm_control_r[dsam_pkg::CTRL_DYN1_BIT]),
        .above_in(alarm_control_r[dsam_pkg::CTRL_POL1_BIT]),
        .data_in(sel1),
        .threshold_in(alarm_one_threshold_r),
        .count_in(alarm_one_sample_count_r),
        .hit_out(hit1)
    );

    dsam_alarm_channel #(
        .WORD_W(dsam_pkg::WORD_W),
        .HIST_DEPTH(HIST_DEPTH)
    ) u_alarm_two (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .sample_stb_in(sample_stb_in),
        .restart_in(restart2),
        .enable_in(en2),
        .dynamic_in(alarm_control_r[dsam_pkg::CTRL_DYN2_BIT]),
        .above_in(alarm_control_r[dsam_pkg::CTRL_POL2_BIT]),
        .data_in(sel2),
        .threshold_in(alarm_two_threshold_r),
        .count_in(alarm_two_sample_count_r),
        .hit_out(hit2)
    );

    dsam_indicator u_indicator (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .sample_stb_in(sample_stb_in),
        .alarm_in(hit1 || hit2),
        .enable_in(alarm_control_r[dsam_pkg::CTRL_IND_EN_BIT]),
        .active_high_in(alarm_control_r[dsam_pkg::CTRL_IND_POL_BIT]),
        .pin_two_in(alarm_control_r[dsam_pkg::CTRL_IND_SEL_BIT]),
        .gpio_one_out(general_io_pin_one_out),
        .gpio_one_oe_n_out(general_io_pin_one_oe_n_out),
        .gpio_two_out(general_io_pin_two_out),
        .gpio_two_oe_n_out(general_io_pin_two_oe_n_out)
    );

    // Checks of the alarm behaviour
    sequence s_hit_one;
        sample_stb_in && hit1;
    endsequence

    sequence s_diag_read;
        rd_diag && !sample_stb_in;
    endsequence

    a_flag_one_set: assert property (@(posedge core_clk_in) disable iff (rst_in)
        s_hit_one ##1 !rd_diag ##1 s_diag_read |=> reg_rvalid_out && reg_rdata_out[8])
        else $error("Alarm one flag not reported on read");
    a_flag_clear: assert property (@(posedge core_clk_in) disable iff (rst_in)
        s_diag_read |=> (flags_r == 2'h0))
        else $error("Flags not cleared by status read");
    a_src_two_sel: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (src2 == 4'h3 && !filt) |-> (sel2 == gyro_z_output_in))
        else $error("Alarm two source code three not raw gyro z");
    a_src_two_off: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (src2 == 4'h0) |-> !hit2)
        else $error("Disabled alarm two fired");
    a_src_one_off: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (src1 == 4'h0) ##1 (src1 == 4'h0) |-> !flag_set[0])
        else $error("Disabled alarm one set its flag");
    a_static_mode: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (en1 && !alarm_control_r[6] && alarm_control_r[4])
        |-> (hit1 == ($signed(sel1) > $signed(alarm_one_threshold_r))))
        else $error("Static alarm one compare wrong");
    a_below_mode: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (en2 && !alarm_control_r[7] && !alarm_control_r[5])
        |-> (hit2 == ($signed(sel2) < $signed(alarm_two_threshold_r))))
        else $error("Static alarm two below compare wrong");
    a_filter_pick: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (filt && src1 == 4'h6) |-> (sel1 == accel_z_filt_in))
        else $error("Filtered data not selected");
    a_reset_zero: assert property (@(posedge core_clk_in)
        rst_in |=> (alarm_control_r == 16'h0000 && flags_r == 2'h0
                    && general_io_pin_one_oe_n_out && general_io_pin_two_oe_n_out))
        else $error("Control not zero after reset");
    a_flag_strobe: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (!sample_stb_in && !rd_diag) |=> $stable(flags_r))
        else $error("Flags moved without a sample strobe");
    a_static_cmp: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (sample_stb_in && en1 && !alarm_control_r[6] && !alarm_control_r[4]
         && $signed(sel1) < $signed(alarm_one_threshold_r)) |=> flags_r[0])
        else $error("Static alarm one below threshold not flagged");
endmodule : dsam_alarm_top

//--- dsam_host_model.sv
`timescale 1ns/1ps
module dsam_host_model (
    input wire logic core_clk_in,
    input wire logic [15:0] reg_rdata_in,
    input wire logic reg_rvalid_in,
    output logic [7:0] reg_addr_out,
    output logic reg_wr_out,
    output logic [15:0] reg_wdata_out,
    output logic reg_rd_out
);
    // Idle bus at time zero
    initial begin
        reg_addr_out = 8'h00;
        reg_wr_out = 1'b0;
        reg_wdata_out = 16'h0000;
        reg_rd_out = 1'b0;
    end

    // One write strobe; released lines show inverted values
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(negedge core_clk_in);
        reg_addr_out = a;
        reg_wdata_out = v;
        reg_wr_out = 1'b1;
        @(negedge core_clk_in);
        reg_wr_out = 1'b0;
        reg_addr_out = ~a;
        reg_wdata_out = ~v;
    endtask : wr

    // One read strobe, data taken with the valid pulse
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        int n;
        @(negedge core_clk_in);
        reg_addr_out = a;
        reg_rd_out = 1'b1;
        @(negedge core_clk_in);
        reg_rd_out = 1'b0;
        reg_addr_out = ~a;
        n = 0;
        while (reg_rvalid_in !== 1'b1 && n < 4) begin
            @(negedge core_clk_in);
            n++;
        end
        v = (n < 4) ? reg_rdata_in : 16'hxxxx; // Missing valid gives unknown
    endtask : rd
endmodule : dsam_host_model

//--- tb_dsam_alarm_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_dsam_alarm_top;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic stb = 1'b0;
    logic [15:0] d [12];
    logic [7:0] ra;
    logic rw, rr, rv, p1, p1oe_n, p2, p2oe_n;
    logic [15:0] wd, rdat, v;
    int n_errors = 0;
    int total_checks = 0;

    // Clock at 10 MHz
    always #50 core_clk_in = ~core_clk_in;

    dsam_alarm_top dsam_alarm_top_inst (.core_clk_in(core_clk_in), .rst_in(rst_in),
        .sample_stb_in(stb), .gyro_x_output_in(d[0]), .gyro_y_output_in(d[1]),
        .gyro_z_output_in(d[2]), .accel_x_output_in(d[3]), .accel_y_output_in(d[4]),
        .accel_z_output_in(d[5]), .gyro_x_filt_in(d[6]), .gyro_y_filt_in(d[7]),
        .gyro_z_filt_in(d[8]), .accel_x_filt_in(d[9]), .accel_y_filt_in(d[10]),
        .accel_z_filt_in(d[11]), .reg_addr_in(ra), .reg_wr_in(rw), .reg_wdata_in(wd),
        .reg_rd_in(rr), .reg_rdata_out(rdat), .reg_rvalid_out(rv),
        .general_io_pin_one_out(p1), .general_io_pin_one_oe_n_out(p1oe_n),
        .general_io_pin_two_out(p2), .general_io_pin_two_oe_n_out(p2oe_n));

    dsam_host_model dsam_host_model_inst (.core_clk_in(core_clk_in), .reg_rdata_in(rdat),
        .reg_rvalid_in(rv), .reg_addr_out(ra), .reg_wr_out(rw), .reg_wdata_out(wd),
        .reg_rd_out(rr));

    // Verdict and end of run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test

    // k sample strobe pulses, one every two cycles
    task automatic strobe(input int k);
        repeat (k) begin
            @(negedge core_clk_in);
            stb = 1'b1;
            @(negedge core_clk_in);
            stb = 1'b0;
        end
    endtask : strobe

    // Read a register and compare
    task automatic rchk(input string nm, input logic [7:0] a, input logic [15:0] e);
        dsam_host_model_inst.rd(a, v);
        `CHK(nm, e, v)
    endtask : rchk

    // Hang guard
    initial begin
        #(20000 * 100);
        n_errors++;
        finish_test();
    end

    initial begin
        logic [7:0] regs [7];
        logic [3:0] s;
        regs = '{8'h3c, 8'h40, 8'h42, 8'h44, 8'h46, 8'h48, 8'h50};
        foreach (d[i]) d[i] = 16'h0000;
        repeat (6) @(negedge core_clk_in);
        rst_in = 1'b0;
        // Reset values and unmapped read
        foreach (regs[i]) rchk("reset", regs[i], 16'h0000);
        dsam_host_model_inst.wr(8'h3c, 16'hffff);
        rchk("diag_ro", 8'h3c, 16'h0000);
        dsam_host_model_inst.wr(8'h44, 16'habcd);
        rchk("count_bits", 8'h44, 16'h00cd);
        $display("test registers done");
        // Source codes 1 to 6, each alarm, static above
        dsam_host_model_inst.wr(8'h40, 16'h0032);
        dsam_host_model_inst.wr(8'h42, 16'h0032);
        for (int i = 1; i <= 6; i++) begin
            s = i[3:0];
            foreach (d[j]) d[j] = 16'h0000;
            d[i-1] = 16'h0064;
            dsam_host_model_inst.wr(8'h48, {4'h0, s, 8'h10});
            strobe(1);
            rchk("alarm1_src", 8'h3c, 16'h0100);
            dsam_host_model_inst.wr(8'h48, {s, 4'h0, 8'h20});
            strobe(1);
            rchk("alarm2_src", 8'h3c, 16'h0200);
        end
        // Static below, signed compare
        foreach (d[j]) d[j] = 16'h0000;
        dsam_host_model_inst.wr(8'h48, 16'h0100);
        d[0] = 16'hfff0;
        strobe(1);
        rchk("below_neg", 8'h3c, 16'h0100);
        d[0] = 16'h0064;
        strobe(1);
        rchk("below_none", 8'h3c, 16'h0000);
        // Filtered data chosen by filter bit
        dsam_host_model_inst.wr(8'h48, 16'h0118);
        d[0] = 16'h0000;
        d[6] = 16'h0064;
        strobe(1);
        rchk("filt_on", 8'h3c, 16'h0100);
        dsam_host_model_inst.wr(8'h48, 16'h0110);
        strobe(1);
        rchk("filt_off", 8'h3c, 16'h0000);
        $display("test static done");
        // Indicator polarity and line select
        d[0] = 16'h0064;
        for (int i = 0; i < 4; i++) begin
            dsam_host_model_inst.wr(8'h48, 16'h0114 | i[15:0]);
            strobe(1);
            repeat (2) @(negedge core_clk_in);
            `CHK("p1_oe_n", i[0], p1oe_n)
            `CHK("p2_oe_n", ~i[0], p2oe_n)
            `CHK("pin_lvl", i[1], i[0] ? p2 : p1)
            `CHK("idle_pin", 1'b0, i[0] ? p1 : p2)
        end
        dsam_host_model_inst.wr(8'h48, 16'h0110);
        strobe(1);
        repeat (2) @(negedge core_clk_in);
        `CHK("off_oe_n", 2'b11, {p1oe_n, p2oe_n})
        `CHK("off_lvl", 2'b00, {p1, p2})
        rchk("clear", 8'h3c, 16'h0100);
        $display("test indicator done");
        // Dynamic alarm over two samples
        d[0] = 16'h0000;
        dsam_host_model_inst.wr(8'h40, 16'h000a);
        dsam_host_model_inst.wr(8'h48, 16'h0150);
        dsam_host_model_inst.wr(8'h44, 16'h0002);
        strobe(2);
        rchk("dyn_fill", 8'h3c, 16'h0000);
        d[0] = 16'h0032;
        strobe(1);
        rchk("dyn_two", 8'h3c, 16'h0100);
        strobe(1);
        rchk("dyn_two_b", 8'h3c, 16'h0100);
        strobe(1);
        rchk("dyn_steady", 8'h3c, 16'h0000);
        // Count zero means one sample
        dsam_host_model_inst.wr(8'h44, 16'h0000);
        d[0] = 16'h0000;
        strobe(1);
        d[0] = 16'h0014;
        strobe(1);
        rchk("dyn_zero", 8'h3c, 16'h0100);
        // Alarm two static below, then dynamic over three samples
        dsam_host_model_inst.wr(8'h48, 16'h1000);
        strobe(1);
        rchk("below_two", 8'h3c, 16'h0200);
        dsam_host_model_inst.wr(8'h48, 16'h10a0);
        dsam_host_model_inst.wr(8'h46, 16'h0003);
        d[0] = 16'h0000;
        strobe(1);
        d[0] = 16'h0064;
        strobe(2);
        rchk("dyn2_fill", 8'h3c, 16'h0000);
        strobe(1);
        rchk("dyn2_three", 8'h3c, 16'h0200);
        $display("test dynamic done");
        // Reset in mid-run returns the registers to zero
        @(negedge core_clk_in);
        rst_in = 1'b1;
        repeat (2) @(negedge core_clk_in);
        rst_in = 1'b0;
        rchk("rst_ctrl", 8'h48, 16'h0000);
        rchk("rst_cnt2", 8'h46, 16'h0000);
        $display("test reset done");
        finish_test();
    end
endmodule : tb_dsam_alarm_top
